/* File: logic/i2cbr_ctrl.sv */
// burst-read controller end: pointer write, repeated start, n-byte read
`timescale 1ns/10ps
`include "i2cbr_map.svh"
module i2cbr_ctrl #(
  parameter int QTR = `I2CBR_QTR_CYC
) (
  input  wire logic       CLK,
  input  wire logic       RST_N,
  input  wire logic       CE,
  i2cbr_if.ctrl           BUS,
  input  wire logic       GO,
  input  wire logic [6:0] TADDR,
  input  wire logic [7:0] RADDR,
  input  wire logic [7:0] COUNT,
  output logic [7:0]      RDATA,
  output logic            RVALID,
  output logic            BUSY,
  output logic            DONE,
  output logic            FAIL
);
  import i2cbr_pkg::*;
  initial if (QTR < 1 || QTR > 65535) $error("QTR out of range");
  typedef struct packed {
    logic [1:0] sda_s;
    i2cbr_cst_t st;
    logic [15:0] tmr;
    logic [1:0] phase;
    logic [3:0] bitn;
    logic [8:0] sh;
    logic [7:0] left;
    logic       scl;
    logic       sda;
    logic [7:0] rdata;
    logic       rvalid;
    logic       busy;
    logic       done;
    logic       fail;
  } i2cbr_cstate_t;
  i2cbr_cstate_t s_q, s_d;
  logic tick;
  assign tick = (s_q.tmr == 16'h0000);
  always_comb begin
    s_d = s_q;
    s_d.sda_s = {s_q.sda_s[0], BUS.sda};
    s_d.rvalid = 1'b0;
    s_d.done = 1'b0;
    s_d.tmr = tick ? 16'(QTR - 1) : s_q.tmr - 16'h0001;
    case (s_q.st)
      CS_IDLE: begin
        s_d.tmr = 16'(QTR - 1);
        if (GO && COUNT != 8'h00) begin
          s_d.st = CS_START;
          s_d.busy = 1'b1;
          s_d.fail = 1'b0;
          s_d.left = COUNT;
          s_d.phase = 2'h0;
          s_d.sda = 1'b0;
        end
      end
      CS_START: if (tick) begin
        s_d.scl = 1'b0;
        s_d.st = CS_BITLO;
        s_d.bitn = 4'h0;
        s_d.sh = (s_q.phase == 2'h2) ? {TADDR, `I2CBR_DIR_READ, 1'b1}
               : {TADDR, `I2CBR_DIR_WRITE, 1'b1};
      end
      CS_BITLO: if (tick) begin
        // data changes in the same cycle that the clock is released high
        s_d.sda = s_q.sh[8];
        if (s_q.phase == 2'h3 && s_q.bitn == 4'h8)
          s_d.sda = (s_q.left == 8'h01);
        s_d.scl = 1'b1;
        s_d.st = CS_BITHI;
      end
      CS_BITHI: if (tick) begin
        s_d.scl = 1'b0;
        s_d.sh = {s_q.sh[7:0], s_q.sda_s[1]};
        s_d.bitn = s_q.bitn + 4'h1;
        s_d.st = CS_BITLO;
        if (s_q.bitn == 4'h8) begin
          s_d.bitn = 4'h0;
          s_d.sh = 9'h1ff;
          if (s_q.phase != 2'h3) begin
            if (s_q.sda_s[1]) begin
              s_d.fail = 1'b1;
              s_d.st = CS_STOP;
            end else if (s_q.phase == 2'h0) begin
              s_d.phase = 2'h1;
              s_d.sh = {RADDR, 1'b1};
            end else if (s_q.phase == 2'h1) begin
              s_d.phase = 2'h2;
              s_d.st = CS_RSTRT;
            end else begin
              s_d.phase = 2'h3;
            end
          end else begin
            // after eight shifts the received byte sits in the low bits
            s_d.rdata = s_q.sh[7:0];
            s_d.rvalid = 1'b1;
            s_d.left = s_q.left - 8'h01;
            if (s_q.left == 8'h01)
              s_d.st = CS_STOP;
          end
        end
      end
      CS_RSTRT: if (tick) begin
        if (!s_q.scl && !s_q.sda)
          s_d.sda = 1'b1;
        else if (!s_q.scl)
          s_d.scl = 1'b1;
        else begin
          s_d.sda = 1'b0;
          s_d.st = CS_START;
        end
      end
      CS_STOP: if (tick) begin
        if (!s_q.scl) begin
          if (s_q.sda)
            s_d.sda = 1'b0;
          else
            s_d.scl = 1'b1;
        end else begin
          s_d.sda = 1'b1;
          s_d.st = CS_DONE;
        end
      end
      CS_DONE: if (tick) begin
        s_d.st = CS_IDLE;
        s_d.busy = 1'b0;
        s_d.done = 1'b1;
      end
      default: s_d.st = CS_IDLE;
    endcase
  end
  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      s_q <= '{sda_s: 2'h3, st: CS_IDLE, tmr: 16'h0000, phase: 2'h0, bitn: 4'h0, sh: 9'h1ff,
               left: 8'h00, scl: 1'b1, sda: 1'b1, rdata: 8'h00, rvalid: 1'b0, busy: 1'b0,
               done: 1'b0, fail: 1'b0};
    end else if (CE) begin
      s_q <= s_d;
    end
  end
  assign BUS.scl_o    = 1'b0;
  assign BUS.scl_oe   = ~s_q.scl;
  assign BUS.sda_c_o  = 1'b0;
  assign BUS.sda_c_oe = ~s_q.sda;
  assign RDATA  = s_q.rdata;
  assign RVALID = s_q.rvalid;
  assign BUSY   = s_q.busy;
  assign DONE   = s_q.done;
  assign FAIL   = s_q.fail;
endmodule

/* File: shared/i2cbr_map.svh */
// constants for the burst-read target and controller
//
// Overview of operation
// - controller starts, sends address with write bit
// - target acknowledges its own write address
// - controller then sends register address byte
// - target acknowledges valid register only, else nacks
// - repeated start, address resent with read bit
// - target acknowledges read address, sends register byte
// - controller acknowledges every byte but the last
// - target keeps sending bytes after each acknowledge
// - controller nacks last byte, then stops
// - acknowledger holds data low through ninth clock
// - nack leaves data high through ninth clock
// - controller reports target nacks as failure
// - target answers only its configured address
`ifndef I2CBR_MAP_SVH
`define I2CBR_MAP_SVH
`define I2CBR_ADDR_A     7'h35
`define I2CBR_ADDR_B     7'h15
`define I2CBR_NUM_REGS   9'h010
`define I2CBR_T_QTR_NS   625
`define I2CBR_CLK_NS     10
`define I2CBR_QTR_CYC    ((`I2CBR_T_QTR_NS + `I2CBR_CLK_NS - 1) / `I2CBR_CLK_NS)
`define I2CBR_DIR_WRITE  1'b0
`define I2CBR_DIR_READ   1'b1
`endif

/* File: shared/i2cbr_pkg.sv */
// types shared by both ends of the burst-read link
package i2cbr_pkg;
  typedef enum logic [5:0] {
    TS_IDLE = 6'h01,
    TS_ADDR = 6'h02,
    TS_ACK  = 6'h04,
    TS_RX   = 6'h08,
    TS_TX   = 6'h10,
    TS_MACK = 6'h20
  } i2cbr_tst_t;
  typedef enum logic [6:0] {
    CS_IDLE  = 7'h01,
    CS_START = 7'h02,
    CS_BITLO = 7'h04,
    CS_BITHI = 7'h08,
    CS_RSTRT = 7'h10,
    CS_STOP  = 7'h20,
    CS_DONE  = 7'h40
  } i2cbr_cst_t;
endpackage

/* File: shared/i2cbr_if.sv */
// two-wire link between controller and target
`timescale 1ns/10ps
interface i2cbr_if;
  logic scl_o;
  logic scl_oe;
  logic sda_c_o;
  logic sda_c_oe;
  logic sda_t_o;
  logic sda_t_oe;
  logic scl;
  logic sda;
  // open drain with pullups: low when any driver pulls low
  assign scl = ~(scl_oe & ~scl_o);
  assign sda = ~((sda_c_oe & ~sda_c_o) | (sda_t_oe & ~sda_t_o));
  modport ctrl (output scl_o, output scl_oe, output sda_c_o, output sda_c_oe, input scl, input sda);
  modport tgt  (output sda_t_o, output sda_t_oe, input scl, input sda);
endinterface

/* File: logic/i2cbr_target.sv */
// burst-read target end: address match, pointer, ack and byte send
`timescale 1ns/10ps
`include "i2cbr_map.svh"
module i2cbr_target #(
  parameter logic [6:0] DEV_ADDR = `I2CBR_ADDR_A,
  parameter int         NUM_REGS = `I2CBR_NUM_REGS
) (
  input  wire logic   CLK,
  input  wire logic   RST_N,
  input  wire logic   CE,
  i2cbr_if.tgt        BUS,
  output logic [7:0]  REG_PTR,
  input  wire logic [7:0] REG_RDATA,
  output logic        REG_RD
);
  import i2cbr_pkg::*;
  initial if (NUM_REGS < 1 || NUM_REGS > 256) $error("NUM_REGS out of range");
  typedef struct packed {
    logic [1:0] scl_s;
    logic [1:0] sda_s;
    logic       scl_p;
    logic       sda_p;
    i2cbr_tst_t st;
    logic [3:0] cnt;
    logic [7:0] sh;
    logic       rw;
    logic       ack;
    logic       got_ptr;
    logic       nack_seen;
    logic [7:0] ptr;
    logic       sda_oe;
    logic       rd;
  } i2cbr_tstate_t;
  i2cbr_tstate_t s_q, s_d;
  logic scl, sda, rise, fall, start, stop;
  assign scl   = s_q.scl_s[1];
  assign sda   = s_q.sda_s[1];
  assign rise  = scl & ~s_q.scl_p;
  assign fall  = ~scl & s_q.scl_p;
  assign start = scl & s_q.scl_p & s_q.sda_p & ~sda;
  assign stop  = scl & s_q.scl_p & ~s_q.sda_p & sda;
  always_comb begin
    s_d = s_q;
    s_d.scl_s = {s_q.scl_s[0], BUS.scl};
    s_d.sda_s = {s_q.sda_s[0], BUS.sda};
    s_d.scl_p = scl;
    s_d.sda_p = sda;
    s_d.rd = 1'b0;
    if (start) begin
      s_d.st = TS_ADDR;
      s_d.cnt = 4'h0;
      s_d.sda_oe = 1'b0;
    end else if (stop) begin
      s_d.st = TS_IDLE;
      s_d.sda_oe = 1'b0;
    end else begin
      case (s_q.st)
        TS_ADDR, TS_RX: begin
          if (rise) begin
            s_d.sh = {s_q.sh[6:0], sda};
            s_d.cnt = s_q.cnt + 4'h1;
          end
          if (fall && s_q.cnt == 4'h8) begin
            s_d.cnt = 4'h0;
            if (s_q.st == TS_ADDR) begin
              s_d.rw = s_q.sh[0];
              s_d.ack = (s_q.sh[7:1] == DEV_ADDR);
              if (s_q.sh[7:1] == DEV_ADDR && s_q.sh[0] == `I2CBR_DIR_WRITE)
                s_d.got_ptr = 1'b0;
            end else begin
              // only the first write byte is a pointer; later bytes are nacked
              s_d.ack = ~s_q.got_ptr && ({1'b0, s_q.sh} < 9'(NUM_REGS));
              if (~s_q.got_ptr && {1'b0, s_q.sh} < 9'(NUM_REGS)) begin
                s_d.ptr = s_q.sh;
                s_d.got_ptr = 1'b1;
              end
            end
            s_d.sda_oe = (s_q.st == TS_ADDR) ? (s_q.sh[7:1] == DEV_ADDR)
                       : (~s_q.got_ptr && ({1'b0, s_q.sh} < 9'(NUM_REGS)));
            s_d.st = TS_ACK;
          end
        end
        TS_ACK: begin
          // line held through the ninth high period; on its fall released, or set to the first data bit for a read
          if (fall) begin
            if (!s_q.ack)
              s_d.st = TS_IDLE;
            else if (s_q.rw) begin
              s_d.st = TS_TX;
              s_d.sh = REG_RDATA;
              s_d.sda_oe = ~REG_RDATA[7];
              s_d.cnt = 4'h1;
              s_d.rd = 1'b1;
            end else begin
              s_d.st = TS_RX;
              s_d.sda_oe = 1'b0;
            end
          end
        end
        TS_TX: begin
          if (fall) begin
            if (s_q.cnt == 4'h8) begin
              s_d.sda_oe = 1'b0;
              s_d.st = TS_MACK;
              s_d.ptr = ({1'b0, s_q.ptr} + 9'h001 >= 9'(NUM_REGS)) ? 8'h00
                      : s_q.ptr + 8'h01;
            end else begin
              s_d.sh = {s_q.sh[6:0], 1'b0};
              s_d.sda_oe = ~s_q.sh[6];
              s_d.cnt = s_q.cnt + 4'h1;
            end
          end
        end
        TS_MACK: begin
          if (rise)
            s_d.nack_seen = sda;
          if (fall) begin
            if (s_q.nack_seen)
              s_d.st = TS_IDLE;
            else begin
              s_d.st = TS_TX;
              s_d.sh = REG_RDATA;
              s_d.sda_oe = ~REG_RDATA[7];
              s_d.cnt = 4'h1;
              s_d.rd = 1'b1;
            end
          end
        end
        default: s_d.sda_oe = 1'b0;
      endcase
    end
  end
  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      s_q <= '{scl_s: 2'h3, sda_s: 2'h3, scl_p: 1'b1, sda_p: 1'b1, st: TS_IDLE, cnt: 4'h0,
               sh: 8'h00, rw: 1'b0, ack: 1'b0, got_ptr: 1'b0, nack_seen: 1'b0, ptr: 8'h00,
               sda_oe: 1'b0, rd: 1'b0};
    end else if (CE) begin
      s_q <= s_d;
    end
  end
  assign BUS.sda_t_o  = 1'b0;
  assign BUS.sda_t_oe = s_q.sda_oe;
  assign REG_PTR = s_q.ptr;
  assign REG_RD  = s_q.rd;
endmodule

/* File: verif/i2cbr_chk.sv */
// wire-level checks on the joined burst-read link
`timescale 1ns/10ps
module i2cbr_chk #(
  parameter logic [6:0] DEV_ADDR = 7'h35,
  parameter int         NUM_REGS = 16
) (
  input wire logic CLK,
  input wire logic RST_N,
  input wire logic sda_c_o,
  input wire logic sda_c_oe,
  input wire logic sda_t_o,
  input wire logic sda_t_oe,
  input wire logic scl,
  input wire logic sda
);
  typedef struct packed {
    logic       scl;
    logic       sda;
    logic [3:0] cnt;
    logic [1:0] nb;
    logic [7:0] sh;
    logic       am;
    logic       rd;
  } i2cbr_chk_t;
  i2cbr_chk_t s_q;
  i2cbr_chk_t s_d;
  logic       t_low;
  logic       c_low;
  logic       rise;
  assign t_low = sda_t_oe & ~sda_t_o;
  assign c_low = sda_c_oe & ~sda_c_o;
  assign rise  = scl & ~s_q.scl;
  // bit and byte position since the last start
  always_comb begin
    s_d     = s_q;
    s_d.scl = scl;
    s_d.sda = sda;
    if (scl && s_q.scl && s_q.sda && !sda) begin
      s_d.cnt = 4'h0;
      s_d.nb  = 2'h0;
    end else if (rise && s_q.cnt == 4'h8) begin
      s_d.cnt = 4'h0;
      if (s_q.nb != 2'h3) s_d.nb = s_q.nb + 2'h1;
    end else if (rise) begin
      s_d.sh  = {s_q.sh[6:0], sda};
      s_d.cnt = s_q.cnt + 4'h1;
      if (s_q.cnt == 4'h7 && s_q.nb == 2'h0) begin
        s_d.am = (s_q.sh[6:0] == DEV_ADDR);
        s_d.rd = sda;
      end
    end
  end
  always_ff @(posedge CLK) begin
    if (!RST_N) s_q <= '0;
    else s_q <= s_d;
  end
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RST_N);
  AST_HIGH_STABLE: assert property (scl && s_q.scl |-> $stable(t_low))
    else $error("target changed data while clock high");
  AST_ADDR_ACK: assert property (rise && s_q.cnt == 4'h8 && s_q.nb == 2'h0 |-> sda == !s_q.am)
    else $error("address byte answer wrong");
  AST_PTR_ACK: assert property (rise && s_q.cnt == 4'h8 && s_q.nb == 2'h1 && s_q.am && !s_q.rd
    |-> sda == (s_q.sh >= NUM_REGS))
    else $error("pointer byte answer wrong");
  AST_MISMATCH_QUIET: assert property (s_q.nb != 2'h0 && !s_q.am |-> !t_low)
    else $error("target pulled data for another address");
  AST_WR_QUIET: assert property (rise && s_q.cnt < 4'h8 && (s_q.nb == 2'h0 || !s_q.rd) |-> !t_low)
    else $error("target pulled data during a write bit");
  AST_CTRL_ACK_FREE: assert property (rise && s_q.cnt == 4'h8 && (s_q.nb == 2'h0 || !s_q.rd) |-> !c_low)
    else $error("controller pulled data on target answer bit");
  AST_CTRL_RD_FREE: assert property (rise && s_q.cnt != 4'h0 && s_q.cnt < 4'h8 && s_q.nb != 2'h0 && s_q.rd
    && s_q.am |-> !c_low)
    else $error("controller pulled data during a read bit");
  AST_TGT_MACK_FREE: assert property (rise && s_q.cnt == 4'h8 && s_q.nb != 2'h0 && s_q.rd |-> !t_low)
    else $error("target pulled data on controller answer bit");
endmodule

/* File: verif/test_i2c_burst_read_ack_slave.sv */
// self-checking bench: controller and target joined back to back
`timescale 1ns/10ps
module test_i2c_burst_read_ack_slave;
  logic       clk;
  logic       rst_n;
  logic       ce;
  logic       go;
  logic [6:0] taddr;
  logic [7:0] raddr;
  logic [7:0] count;
  logic [7:0] rdata;
  logic       rvalid;
  logic       busy;
  logic       done;
  logic       fail;
  logic [7:0] reg_ptr;
  logic       reg_rd;
  logic [7:0] rd_cnt;
  logic [8:0] e;
  logic [7:0] bank [16];
  logic [8:0] exp_q [$];
  int         failures;
  int         total_checks;
  i2cbr_if bus ();
  i2cbr_ctrl #(.QTR(4)) i2cbr_ctrl_i (
    .CLK(clk), .RST_N(rst_n), .CE(ce), .BUS(bus), .GO(go), .TADDR(taddr), .RADDR(raddr),
    .COUNT(count), .RDATA(rdata), .RVALID(rvalid), .BUSY(busy), .DONE(done), .FAIL(fail));
  i2cbr_target #(.DEV_ADDR(7'h35), .NUM_REGS(16)) i2cbr_target_i (
    .CLK(clk), .RST_N(rst_n), .CE(ce), .BUS(bus), .REG_PTR(reg_ptr),
    .REG_RDATA(bank[reg_ptr[3:0]]), .REG_RD(reg_rd));
  i2cbr_chk #(.DEV_ADDR(7'h35), .NUM_REGS(16)) i2cbr_chk_i (
    .CLK(clk), .RST_N(rst_n), .sda_c_o(bus.sda_c_o), .sda_c_oe(bus.sda_c_oe),
    .sda_t_o(bus.sda_t_o), .sda_t_oe(bus.sda_t_oe), .scl(bus.scl), .sda(bus.sda));
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  task automatic chk(input logic [8:0] seen, input logic [8:0] exp, input string what);
    total_checks++;
    if (seen !== exp) begin
      failures++;
      $display("unexpected %s: expected %h, seen %h", what, exp, seen);
    end
  endtask
  task automatic give_verdict;
    if (failures == 0 && total_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic do_reset;
    rst_n = 1'b0;
    repeat (8) @(negedge clk);
    rst_n = 1'b1;
  endtask
  task automatic run(input logic [6:0] ta, input logic [7:0] ra, input logic [7:0] n);
    logic bad;
    int   k;
    bad = (ta != 7'h35) || (ra >= 8'h10);
    for (k = 0; k < n && !bad; k++) exp_q.push_back({1'b0, bank[(ra + k) % 16]});
    exp_q.push_back({1'b1, 7'h00, bad});
    @(negedge clk);
    rd_cnt = 8'h00;
    taddr = ta;
    raddr = ra;
    count = n;
    go = 1'b1;
    for (k = 0; k < 100 && !busy; k++) @(negedge clk);
    go = 1'b0;
    for (k = 0; k < 5000 && busy; k++) @(negedge clk);
    repeat (4) @(negedge clk);
    chk(9'(exp_q.size()), 9'h000, "pending results");
    if (!bad) begin
      chk({1'b0, reg_ptr}, 9'((ra + n) % 16), "pointer");
      chk({1'b0, rd_cnt}, {1'b0, n}, "load pulses");
    end
  endtask
  // oldest note is compared against each result as it appears;
  // ce here is still the value the last rising edge used, so a frozen pulse is not counted twice
  always @(negedge clk) begin
    if (ce === 1'b1 && reg_rd === 1'b1) rd_cnt = rd_cnt + 8'h01;
    if (ce === 1'b1 && (rvalid === 1'b1 || done === 1'b1)) begin
      e = (exp_q.size() != 0) ? exp_q.pop_front() : 9'h1ff;
      chk(done ? {8'h80, fail} : {1'b0, rdata}, e, "result");
    end
    // random freeze cycles for both ends together
    ce = ($urandom_range(7) != 0);
  end
  initial begin
    repeat (60000) @(posedge clk);
    failures++;
    give_verdict();
  end
  initial begin
    failures = 0;
    total_checks = 0;
    rd_cnt = 8'h00;
    rst_n = 1'b0;
    ce = 1'b1;
    go = 1'b0;
    taddr = 7'h35;
    raddr = 8'h00;
    count = 8'h01;
    void'($urandom(32'hf19a5d0f));
    foreach (bank[i]) bank[i] = 8'($urandom());
    do_reset();
    run(7'h35, 8'h00, 8'h01);
    run(7'h35, 8'h0e, 8'h04);
    run(7'h15, 8'h02, 8'h02);
    run(7'h35, 8'h10, 8'h01);
    run(7'h35, 8'h0f, 8'h02);
    repeat (3) run(7'h35, 8'($urandom_range(15)), 8'($urandom_range(5, 1)));
    do_reset();
    run(7'h35, 8'h05, 8'h03);
    give_verdict();
  end
endmodule
